// ==== rtl/smsd_defines.svh ====
// Constants of the serial MAC signal-detect block.
`ifndef SMSD_DEFINES_SVH
`define SMSD_DEFINES_SVH
`define SMSD_IDX_CTRL0 5'h00
`define SMSD_IDX_STAT 5'h01
`define SMSD_IDX_EXT21 5'h15
`define SMSD_IDX_MODE 5'h17
`define SMSD_IDX_FXSCR 5'h1f
`define SMSD_AN_BIT 12
`define SMSD_SPD_LSB 13
`define SMSD_SPD_MSB 6
`define SMSD_DPX_BIT 8
`define SMSD_SFP_BIT 15
`define SMSD_CTRL0_RST 16'h1140
`define SMSD_M_PAR_CU 3'h0
`define SMSD_M_SG_CU 3'h1
`define SMSD_M_SG_SD 3'h2
`define SMSD_M_SG_AMS 3'h3
`define SMSD_M_SD_CU 3'h4
`define SMSD_SPD_100 2'h1
`define SMSD_SPD_1000 2'h2
`define SMSD_STRAP_FN 3
`define SMSD_STRAP_DIR 1
`define SMSD_BOOT_END 2'h3
`define SMSD_SD_WIN_NS 2000
`define SMSD_CLK_MHZ 100
`define SMSD_SD_WIN_CYC (`SMSD_SD_WIN_NS * `SMSD_CLK_MHZ / 1000)
`define SMSD_SCLK_WRAP 2'h3
`endif

// ==== rtl/smsd_pkg.sv ====
// Types of the serial MAC signal-detect block.
package smsd_pkg;
    typedef enum logic [1:0] {
        SMSD_BOOT = 2'b01,
        SMSD_RUN = 2'b10
    } smsd_phase_e;
    typedef enum logic [1:0] {
        SMSD_LOS_IN = 2'h0,
        SMSD_SD_OUT_LO = 2'h1,
        SMSD_SD_IN = 2'h2,
        SMSD_SD_OUT_HI = 2'h3
    } smsd_pin_e;
    typedef logic [2:0][1:0] smsd_sync_t;
    typedef struct packed {
        smsd_phase_e phase;
        logic [1:0] boot;
        smsd_pin_e pin_cfg;
        logic [15:0] ctrl0;
        logic sfp;
        logic [2:0] mode;
        logic script_done;
        logic wr;
        logic [4:0] widx;
        logic [31:0] hrdata;
        logic rdy;
        logic resp;
        smsd_sync_t s_tx, s_fi, s_pb, s_pin, s_strap;
        logic [1:0] f_tx, f_fi, f_pb, f_pin, f_strap;
        logic [7:0] win;
        logic sig_det, sig_loss, pin_out, pin_oe;
        logic [1:0] sclk_cnt;
        logic sclk_p, sclk_n, fo_p, fo_n, ro_p, ro_n, pa_p, pa_n;
        logic [1:0] speed;
    } smsd_state_s;
endpackage

// ==== rtl/smsd_top.sv ====
// Serial MAC mode control and loss/detect pin logic with AHB-Lite registers.
`timescale 1ns/1ps
`include "smsd_defines.svh"
module smsd_top (
    input wire logic CLK, // System clock, 100 MHz.
    input wire logic SYS_RST, // Synchronous reset, active high.
    input wire logic HSEL, // AHB-Lite slave select.
    input wire logic [31:0] HADDR, // AHB-Lite address.
    input wire logic [1:0] HTRANS, // AHB-Lite transfer type.
    input wire logic HWRITE, // AHB-Lite write flag.
    input wire logic [2:0] HSIZE, // AHB-Lite size, word only.
    input wire logic [31:0] HWDATA, // AHB-Lite write data.
    input wire logic HREADY, // AHB-Lite bus ready.
    output logic [31:0] HRDATA, // AHB-Lite read data.
    output logic HREADYOUT, // AHB-Lite slave ready.
    output logic HRESP, // AHB-Lite response.
    input wire logic [3:0] STRAP_CONFIG_WORD1, // Startup strap pins.
    input wire logic COPPER_LINK_UP, // Copper link established.
    input wire logic COPPER_RX_BIT, // Copper receive data bit.
    input wire logic SERIAL_TX_IN_POS, // Serial TX input, positive.
    input wire logic SERIAL_TX_IN_NEG, // Serial TX input, negative.
    input wire logic FIBER_IN_POS, // Fiber receive input, positive.
    input wire logic FIBER_IN_NEG, // Fiber receive input, negative.
    input wire logic PAIR_B_IN_POS, // Twisted pair B input, positive.
    input wire logic PAIR_B_IN_NEG, // Twisted pair B input, negative.
    input wire logic LOSD_IN, // Loss/detect pin level.
    output logic LOSD_OUT, // Loss/detect pin drive value.
    output logic LOSD_OE, // Loss/detect pin enable, high drives.
    output logic SIG_DETECT, // Resolved signal detect.
    output logic SIG_LOSS, // Resolved loss of signal.
    output logic FX_ACTIVE, // 100 Mb fiber mode active.
    output logic [1:0] LINK_SPEED, // 0: 10, 1: 100, 2: 1000 Mbps.
    output logic SERIAL_CLOCK_OUT_POS, // Serial clock out, positive.
    output logic SERIAL_CLOCK_OUT_NEG, // Serial clock out, negative.
    output logic FIBER_OUT_POS, // Fiber transmit, positive.
    output logic FIBER_OUT_NEG, // Fiber transmit, negative.
    output logic SERIAL_RX_OUT_POS, // Serial RX output, positive.
    output logic SERIAL_RX_OUT_NEG, // Serial RX output, negative.
    output logic PAIR_A_OUT_POS, // Twisted pair A out, positive.
    output logic PAIR_A_OUT_NEG // Twisted pair A out, negative.
);
    smsd_pkg::smsd_state_s q, d;
    logic fx_q;
    logic tx_bit;
    logic pin_f;
    logic sercu_q;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // A synchronised pair changes once its second and third stages agree.
    function automatic logic [1:0] filt(input logic [1:0] prev,
                                        input smsd_pkg::smsd_sync_t s);
        filt = prev;
        if (s[1] == s[2]) begin
            filt = s[2];
        end
    endfunction

    function automatic logic diff_bit(input logic [1:0] pn);
        diff_bit = pn[1] & ~pn[0];
    endfunction

    function automatic logic is_fx(input smsd_pkg::smsd_state_s s);
        logic cu_mode;
        cu_mode = (s.mode == `SMSD_M_PAR_CU) || (s.mode == `SMSD_M_SG_CU);
        is_fx = cu_mode && !s.ctrl0[`SMSD_AN_BIT]
            && s.ctrl0[`SMSD_SPD_LSB] && !s.ctrl0[`SMSD_SPD_MSB]
            && s.ctrl0[`SMSD_DPX_BIT] && s.script_done;
    endfunction

    function automatic logic [31:0] rd(input smsd_pkg::smsd_state_s s,
                                       input logic [4:0] idx);
        rd = 32'h0;
        unique case (idx)
            `SMSD_IDX_CTRL0: rd = {16'h0, s.ctrl0};
            `SMSD_IDX_STAT: rd = {25'h0, COPPER_LINK_UP, s.pin_cfg,
                                  s.pin_oe, is_fx(s), s.sig_loss,
                                  s.sig_det};
            `SMSD_IDX_EXT21: rd = {16'h0, s.sfp, 15'h0};
            `SMSD_IDX_MODE: rd = {29'h0, s.mode};
            `SMSD_IDX_FXSCR: rd = {31'h0, s.script_done};
            default: rd = 32'h0;
        endcase
    endfunction

    assign fx_q = is_fx(q);
    assign tx_bit = diff_bit(q.f_tx);
    assign pin_f = q.f_pin[1];
    assign sercu_q = (q.mode == `SMSD_M_SG_CU) || (q.mode == `SMSD_M_SD_CU);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic acc;
        logic ok;
        logic edge_seen;
        logic fx;
        logic los_on;
        logic sd_in_on;
        logic sd_out_on;
        logic sclk_on;
        acc = 1'b0;
        ok = 1'b0;
        edge_seen = 1'b0;
        fx = 1'b0;
        los_on = 1'b0;
        sd_in_on = 1'b0;
        sd_out_on = 1'b0;
        sclk_on = 1'b0;
        d = q;

        // Input synchronisers: stage 0 feeds only stage 1.
        d.s_tx = {q.s_tx[1:0], {SERIAL_TX_IN_POS, SERIAL_TX_IN_NEG}};
        d.s_fi = {q.s_fi[1:0], {FIBER_IN_POS, FIBER_IN_NEG}};
        d.s_pb = {q.s_pb[1:0], {PAIR_B_IN_POS, PAIR_B_IN_NEG}};
        d.s_pin = {q.s_pin[1:0], {LOSD_IN, 1'b0}};
        d.s_strap = {q.s_strap[1:0],
                     {STRAP_CONFIG_WORD1[`SMSD_STRAP_FN],
                      STRAP_CONFIG_WORD1[`SMSD_STRAP_DIR]}};
        d.f_tx = filt(q.f_tx, q.s_tx);
        d.f_fi = filt(q.f_fi, q.s_fi);
        d.f_pb = filt(q.f_pb, q.s_pb);
        d.f_pin = filt(q.f_pin, q.s_pin);
        d.f_strap = filt(q.f_strap, q.s_strap);

        // Straps are caught once the synchroniser has settled.
        unique case (q.phase)
            smsd_pkg::SMSD_BOOT: begin
                d.boot = q.boot + 2'h1;
                if (q.boot == `SMSD_BOOT_END) begin
                    // The filtered straps settle on this very edge.
                    d.pin_cfg = smsd_pkg::smsd_pin_e'(d.f_strap);
                    d.phase = smsd_pkg::SMSD_RUN;
                end
            end
            smsd_pkg::SMSD_RUN: begin
                d.pin_cfg = q.pin_cfg;
            end
        endcase

        // Bus slave: writes land in the data phase after the address.
        if (q.wr) begin
            unique case (q.widx)
                `SMSD_IDX_CTRL0: d.ctrl0 = HWDATA[15:0];
                `SMSD_IDX_EXT21: d.sfp = HWDATA[`SMSD_SFP_BIT];
                `SMSD_IDX_MODE: d.mode = HWDATA[2:0];
                `SMSD_IDX_FXSCR: d.script_done = HWDATA[0];
                default: d.wr = 1'b0;
            endcase
        end
        acc = HSEL && HTRANS[1] && HREADY;
        ok = (HADDR[31:7] == 25'h0) && (HADDR[1:0] == 2'h0);
        d.wr = acc && HWRITE && ok;
        d.widx = HADDR[6:2];
        d.rdy = 1'b1;
        d.resp = 1'b0;
        if (acc && !HWRITE) begin
            d.hrdata = ok ? rd(d, HADDR[6:2]) : 32'h0;
        end

        // Internal detection from serial TX activity.
        edge_seen = diff_bit(d.f_tx) != tx_bit;
        if (edge_seen) begin
            d.win = 8'(`SMSD_SD_WIN_CYC);
        end else if (q.win != 8'h0) begin
            d.win = q.win - 8'h1;
        end

        // Loss/detect pin function.
        fx = fx_q;
        los_on = (q.pin_cfg == smsd_pkg::SMSD_LOS_IN) && q.sfp;
        sd_in_on = (q.pin_cfg == smsd_pkg::SMSD_SD_IN) && !q.sfp;
        sd_out_on = q.pin_cfg[0] && !q.sfp;
        d.sig_loss = 1'b0;
        d.pin_oe = 1'b0;
        d.pin_out = 1'b0;
        if (q.phase != smsd_pkg::SMSD_RUN || fx) begin
            d.sig_det = 1'b0;
        end else if (los_on) begin
            d.sig_loss = pin_f;
            d.sig_det = !pin_f;
        end else if (sd_in_on) begin
            d.sig_det = pin_f;
        end else begin
            d.sig_det = (d.win != 8'h0);
        end
        if (q.phase == smsd_pkg::SMSD_RUN && !fx && sd_out_on) begin
            d.pin_oe = 1'b1;
            d.pin_out = (sercu_q && COPPER_LINK_UP) ^
                        (q.pin_cfg == smsd_pkg::SMSD_SD_OUT_LO);
        end

        // Serial clock divider.
        sclk_on = (q.mode == `SMSD_M_SG_CU) || (q.mode == `SMSD_M_SG_SD)
                  || (q.mode == `SMSD_M_SG_AMS);
        d.sclk_cnt = q.sclk_cnt + 2'h1;
        if (!sclk_on) begin
            d.sclk_p = 1'b0;
            d.sclk_n = 1'b0;
        end else if (q.sclk_cnt == `SMSD_SCLK_WRAP) begin
            d.sclk_p = !q.sclk_p;
            d.sclk_n = q.sclk_p;
        end else begin
            d.sclk_p = q.sclk_p;
            d.sclk_n = !q.sclk_p;
        end

        // Data paths per operating mode.
        d.fo_p = 1'b0;
        d.fo_n = 1'b0;
        d.ro_p = 1'b0;
        d.ro_n = 1'b0;
        d.pa_p = 1'b0;
        d.pa_n = 1'b0;
        if (q.mode == `SMSD_M_SG_SD) begin
            d.fo_p = tx_bit;
            d.fo_n = !tx_bit;
            d.ro_p = diff_bit(q.f_fi);
            d.ro_n = !diff_bit(q.f_fi);
        end else if (fx) begin
            d.pa_p = tx_bit;
            d.pa_n = !tx_bit;
            d.ro_p = diff_bit(q.f_pb);
            d.ro_n = !diff_bit(q.f_pb);
        end else if (sercu_q) begin
            d.ro_p = COPPER_RX_BIT;
            d.ro_n = !COPPER_RX_BIT;
        end

        if (q.mode == `SMSD_M_SD_CU || q.ctrl0[`SMSD_AN_BIT]) begin
            d.speed = `SMSD_SPD_1000;
        end else begin
            d.speed = {q.ctrl0[`SMSD_SPD_MSB], q.ctrl0[`SMSD_SPD_LSB]};
        end

        if (SYS_RST) begin
            d = '0;
            d.phase = smsd_pkg::SMSD_BOOT;
            d.ctrl0 = `SMSD_CTRL0_RST;
        end
    end

    always_ff @(posedge CLK) begin
        q <= d;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign HRDATA = q.hrdata;
    assign HREADYOUT = q.rdy;
    assign HRESP = q.resp;
    assign LOSD_OUT = q.pin_out;
    assign LOSD_OE = q.pin_oe;
    assign SIG_DETECT = q.sig_det;
    assign SIG_LOSS = q.sig_loss;
    assign LINK_SPEED = q.speed;
    assign SERIAL_CLOCK_OUT_POS = q.sclk_p;
    assign SERIAL_CLOCK_OUT_NEG = q.sclk_n;
    assign FIBER_OUT_POS = q.fo_p;
    assign FIBER_OUT_NEG = q.fo_n;
    assign SERIAL_RX_OUT_POS = q.ro_p;
    assign SERIAL_RX_OUT_NEG = q.ro_n;
    assign PAIR_A_OUT_POS = q.pa_p;
    assign PAIR_A_OUT_NEG = q.pa_n;

    logic fx_flag_q;
    always_ff @(posedge CLK) begin
        fx_flag_q <= SYS_RST ? 1'b0 : fx_q;
    end
    assign FX_ACTIVE = fx_flag_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_running;
        q.phase == smsd_pkg::SMSD_RUN;
    endsequence
    sequence s_link_held;
        (LOSD_OE && sercu_q && COPPER_LINK_UP) [*2];
    endsequence

    chk_fx_pin_off: assert property (fx_q |=> !LOSD_OE && !SIG_DETECT)
        else $error("pin used in fiber mode");
    chk_strap_hold: assert property (s_running |=> $stable(q.pin_cfg))
        else $error("strap config changed after capture");
    chk_loss_gate: assert property (SIG_LOSS |->
        $past(q.sfp) && $past(q.pin_cfg) == smsd_pkg::SMSD_LOS_IN)
        else $error("loss flagged outside SFP mode");
    chk_sd_input: assert property (s_running ##0
        (q.pin_cfg == smsd_pkg::SMSD_SD_IN && !q.sfp && !fx_q && pin_f)
        |=> SIG_DETECT)
        else $error("high detect input not honoured");
    chk_oe_ieee: assert property (LOSD_OE |-> !$past(q.sfp)
        && $past(q.pin_cfg[0]))
        else $error("detect pin driven outside its config");
    chk_link_out: assert property (s_link_held |->
        LOSD_OUT == (q.pin_cfg == smsd_pkg::SMSD_SD_OUT_HI))
        else $error("detect output not asserted on link");
    chk_sclk_gate: assert property ((SERIAL_CLOCK_OUT_POS ||
        SERIAL_CLOCK_OUT_NEG) |-> $past(q.mode) inside
        {`SMSD_M_SG_CU, `SMSD_M_SG_SD, `SMSD_M_SG_AMS})
        else $error("serial clock driven in wrong mode");
    chk_fiber_gate: assert property ((FIBER_OUT_POS || FIBER_OUT_NEG)
        |-> $past(q.mode) == `SMSD_M_SG_SD)
        else $error("fiber output driven in wrong mode");
    chk_speed_1000: assert property (q.mode == `SMSD_M_SD_CU
        |=> LINK_SPEED == `SMSD_SPD_1000)
        else $error("1000BASE-X MAC not at 1000 Mbps");
    chk_pair_a: assert property (fx_q && q.mode != `SMSD_M_SG_SD
        |=> PAIR_A_OUT_POS == $past(tx_bit))
        else $error("pair A not carrying transmit data");
    chk_internal_det: assert property (s_running ##0
        (q.pin_cfg == smsd_pkg::SMSD_SD_OUT_HI && !fx_q && q.win > 8'h1)
        |=> SIG_DETECT)
        else $error("internal detect lost during activity");
endmodule // smsd_top

// ==== tb/smsd_far_end.sv ====
// Far-side model: serial MAC transmit pair, fiber receiver and detect pin.
`timescale 1ns/1ps
module smsd_far_end (
    input wire logic run, // Frame in progress, link clock runs.
    input wire logic pin_en, // Model drives the detect pin.
    input wire logic pin_lvl, // Level put on the detect pin.
    output logic tx_p, // Serial transmit pair, positive.
    output logic tx_n, // Serial transmit pair, negative.
    output logic fi_p, // Fiber receive pair, positive.
    output logic fi_n, // Fiber receive pair, negative.
    output logic pb_p, // Twisted pair B, positive.
    output logic pb_n, // Twisted pair B, negative.
    output logic pin_drv, // Detect pin drive value.
    output logic pin_oe // Detect pin drive enable.
);
    logic lclk;
    logic bit_q;
    // The link clock stands still outside frames, so the lines go quiet.
    initial begin
        lclk = 1'b0;
        bit_q = 1'b0;
        #37;
        forever begin
            #80;
            lclk = run & ~lclk;
        end
    end
    always @(posedge lclk) bit_q <= ~bit_q;
    assign tx_p = bit_q;
    assign tx_n = ~bit_q;
    assign fi_p = bit_q;
    assign fi_n = ~bit_q;
    assign pb_p = ~bit_q;
    assign pb_n = bit_q;
    assign pin_oe = pin_en;
    assign pin_drv = pin_lvl;
endmodule // smsd_far_end

// ==== tb/smsd_top_test.sv ====
// Self-checking bench for the serial MAC signal-detect block.
`timescale 1ns/1ps
module smsd_top_test;
    logic CLK, SYS_RST, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS, LINK_SPEED;
    logic [2:0] HSIZE;
    logic [3:0] STRAP_CONFIG_WORD1;
    logic COPPER_LINK_UP, COPPER_RX_BIT, LOSD_IN, LOSD_OUT, LOSD_OE;
    logic SERIAL_TX_IN_POS, SERIAL_TX_IN_NEG, FIBER_IN_POS, FIBER_IN_NEG;
    logic PAIR_B_IN_POS, PAIR_B_IN_NEG, SIG_DETECT, SIG_LOSS, FX_ACTIVE;
    logic SERIAL_CLOCK_OUT_POS, SERIAL_CLOCK_OUT_NEG, FIBER_OUT_POS;
    logic FIBER_OUT_NEG, SERIAL_RX_OUT_POS, SERIAL_RX_OUT_NEG;
    logic PAIR_A_OUT_POS, PAIR_A_OUT_NEG;
    logic run, p_en, p_lvl, p_drv, p_oe, flick;
    int n_mismatch = 0;
    int checked = 0;

    smsd_top dut_u (.*);
    smsd_far_end far_u (.run(run), .pin_en(p_en), .pin_lvl(p_lvl),
        .tx_p(SERIAL_TX_IN_POS), .tx_n(SERIAL_TX_IN_NEG),
        .fi_p(FIBER_IN_POS), .fi_n(FIBER_IN_NEG), .pb_p(PAIR_B_IN_POS),
        .pb_n(PAIR_B_IN_NEG), .pin_drv(p_drv), .pin_oe(p_oe));
    assign HREADY = HREADYOUT;
    // An undriven pin toggles every clock, so the detect pin filter never settles and holds its last settled level.
    assign LOSD_IN = LOSD_OE ? LOSD_OUT : (p_oe ? p_drv : flick);
    always @(posedge CLK) flick <= ~flick;

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, d,
        output logic [31:0] r);
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
        chk_bit("hresp", 1'b0, HRESP);
        HSEL <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, e, input string nm);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk_word(nm, e, r);
    endtask

    task automatic rst(input logic [3:0] s);
        @(posedge CLK) STRAP_CONFIG_WORD1 <= s;
        SYS_RST <= 1'b1;
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        wt(10);
    endtask

    task automatic tog(output logic [2:0] s);
        logic [2:0] p;
        logic [2:0] c;
        s = 3'h0;
        p = {PAIR_A_OUT_POS, FIBER_OUT_POS, SERIAL_CLOCK_OUT_POS};
        repeat (40) begin
            @(negedge CLK);
            c = {PAIR_A_OUT_POS, FIBER_OUT_POS, SERIAL_CLOCK_OUT_POS};
            s = s | (c ^ p);
            p = c;
        end
        wt(1);
    endtask

    task automatic t_regs;
        logic [31:0] r;
        rd_chk(32'h00, 32'h1140, "ctrl0 reset");
        rd_chk(32'h54, 32'h0, "ext21 reset");
        ahb(1'b1, 32'h40, 32'hffff, r);
        rd_chk(32'h40, 32'h0, "unmapped");
        ahb(1'b1, 32'h5c, 32'h4, r);
        rd_chk(32'h5c, 32'h4, "mode");
    endtask

    task automatic t_sd_in;
        logic [31:0] r;
        @(posedge CLK) p_lvl <= 1'b1;
        ahb(1'b1, 32'h54, 32'h8000, r);
        wt(8);
        chk_bit("detect sfp", 1'b0, SIG_DETECT);
        ahb(1'b1, 32'h54, 32'h0, r);
        wt(8);
        chk_bit("detect high", 1'b1, SIG_DETECT);
        chk_bit("detect in oe", 1'b0, LOSD_OE);
        @(posedge CLK) p_lvl <= 1'b0;
        STRAP_CONFIG_WORD1 <= 4'ha;
        wt(8);
        chk_bit("detect low", 1'b0, SIG_DETECT);
        ahb(1'b0, 32'h4, 32'h0, r);
        chk_word("pin cfg", {30'h0, smsd_pkg::SMSD_SD_IN},
            {30'h0, r[5:4]});
    endtask

    task automatic t_los;
        logic [31:0] r;
        rst(4'h0);
        @(posedge CLK) p_lvl <= 1'b1;
        wt(8);
        chk_bit("loss off", 1'b0, SIG_LOSS);
        @(posedge CLK) run <= 1'b1;
        wt(60);
        chk_bit("tx detect", 1'b1, SIG_DETECT);
        @(posedge CLK) run <= 1'b0;
        wt(230);
        chk_bit("tx quiet", 1'b0, SIG_DETECT);
        ahb(1'b1, 32'h54, 32'h8000, r);
        wt(8);
        chk_bit("loss on", 1'b1, SIG_LOSS);
        chk_bit("loss oe", 1'b0, LOSD_OE);
        @(posedge CLK) p_lvl <= 1'b0;
        wt(8);
        chk_bit("loss clear", 1'b0, SIG_LOSS);
    endtask

    task automatic t_sd_out;
        logic [31:0] r;
        @(posedge CLK) p_en <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            rst(i ? 4'h2 : 4'ha);
            ahb(1'b1, 32'h5c, 32'h1, r);
            @(posedge CLK) COPPER_LINK_UP <= 1'b1;
            wt(4);
            chk_bit("out oe", 1'b1, LOSD_OE);
            chk_bit("out link", i == 0, LOSD_OUT);
            ahb(1'b1, 32'h5c, 32'h0, r);
            wt(4);
            chk_bit("out parallel", i != 0, LOSD_OUT);
            @(posedge CLK) COPPER_LINK_UP <= 1'b0;
            wt(4);
            chk_bit("out down", i != 0, LOSD_OUT);
        end
    endtask

    task automatic t_fx;
        logic [31:0] r;
        logic [2:0] s;
        rst(4'h8);
        @(posedge CLK) p_en <= 1'b1;
        p_lvl <= 1'b1;
        ahb(1'b1, 32'h5c, 32'h1, r);
        ahb(1'b1, 32'h00, 32'h2100, r);
        wt(4);
        chk_bit("fx early", 1'b0, FX_ACTIVE);
        ahb(1'b1, 32'h7c, 32'h1, r);
        wt(4);
        chk_bit("fx on", 1'b1, FX_ACTIVE);
        chk_bit("fx detect", 1'b0, SIG_DETECT);
        chk_bit("fx oe", 1'b0, LOSD_OE);
        chk_word("fx speed", 32'h1, {30'h0, LINK_SPEED});
        @(posedge CLK) run <= 1'b1;
        tog(s);
        chk_bit("pair a", 1'b1, s[2]);
        @(posedge CLK) run <= 1'b0;
        wt(8);
        chk_bit("pair a bit", SERIAL_TX_IN_POS, PAIR_A_OUT_POS);
        chk_bit("pair b bit", PAIR_B_IN_POS, SERIAL_RX_OUT_POS);
    endtask

    task automatic t_modes;
        logic [31:0] r;
        logic [2:0] s;
        ahb(1'b1, 32'h00, 32'h2000, r);
        ahb(1'b1, 32'h7c, 32'h0, r);
        @(posedge CLK) run <= 1'b1;
        for (int m = 0; m < 5; m++) begin
            ahb(1'b1, 32'h5c, 32'(m), r);
            wt(4);
            tog(s);
            chk_bit("sclk", m inside {[1:3]}, s[0]);
            chk_bit("fiber out", m == 2, s[1]);
            chk_bit("pair a idle", 1'b0, s[2]);
            chk_word("speed", (m == 4) ? 32'h2 : 32'h1,
                {30'h0, LINK_SPEED});
        end
        @(posedge CLK) run <= 1'b0;
    endtask

    initial begin
        {HSEL, HWRITE, HADDR, HWDATA, HTRANS} = '0;
        HSIZE = 3'h2;
        SYS_RST = 1'b1;
        STRAP_CONFIG_WORD1 = 4'h8;
        {COPPER_LINK_UP, run, p_lvl, flick} = '0;
        COPPER_RX_BIT = 1'b1;
        p_en = 1'b1;
        rst(4'h8);
        t_regs;
        t_sd_in;
        t_los;
        t_sd_out;
        t_fx;
        t_modes;
        print_verdict;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        print_verdict;
    end
endmodule // smsd_top_test
